// ==== core/dso_pkg.sv ====
package dso_pkg;
    localparam int NUM_TERM = 5;
    localparam int SEL_W    = 8;
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_OHLVL = 8'h04;
    localparam logic [7:0] OFS_LCLVL = 8'h08;
    localparam logic [7:0] OFS_SEL0  = 8'h0C;
    localparam logic [7:0] OFS_STEP  = 8'h04;
    localparam logic [7:0] OFS_RELAY = 8'h20;
    localparam logic [7:0] OFS_LIFE  = 8'h24;
    localparam logic [7:0] OFS_STAT  = 8'h28;
    // Field positions.
    localparam int CTRL_FAN_LSB  = 0;
    localparam int CTRL_LCM_LSB  = 2;
    localparam int CTRL_SRC_BIT  = 4;
    localparam int CTRL_SWF_BIT  = 8;
    localparam int CTRL_SWR_BIT  = 9;
    localparam int CTRL_CLR_BIT  = 16;
    localparam int LIFE_FAN_BIT  = 1;
    localparam int STAT_CODE_LSB = 8;
    localparam int STAT_TRIP_BIT = 16;
    // Reset values.
    localparam logic [1:0]  RST_FAN_CTL = 2'h0;
    localparam logic [1:0]  RST_LC_MODE = 2'h0;
    localparam logic [7:0]  RST_OH_LVL  = 8'h78;
    localparam logic [15:0] RST_LC_LVL  = 16'h0000;
    localparam logic [7:0]  RST_SEL     = 8'h00;
    // Modes and limits.
    localparam logic [1:0] FAN_CTL_NO_WARN = 2'h1;
    localparam logic [1:0] LC_MODE_RUN     = 2'h0;
    localparam logic [1:0] LC_MODE_CONST   = 2'h1;
    localparam logic [7:0] OH_LVL_MAX      = 8'hC8;
    localparam int FAN_NUM = 3;
    localparam int FAN_DEN = 4;
    // Output selector codes.
    localparam logic [7:0] CODE_FAN  = 8'h28;
    localparam logic [7:0] CODE_FR   = 8'h29;
    localparam logic [7:0] CODE_OH   = 8'h2A;
    localparam logic [7:0] CODE_LC   = 8'h2B;
    localparam logic [7:0] CODE_RDY  = 8'h32;
    localparam logic [7:0] CODE_FWD  = 8'h33;
    localparam logic [7:0] CODE_REV  = 8'h34;
    localparam logic [7:0] CODE_MAJ  = 8'h35;
    // Hardware trip codes.
    localparam logic [7:0] TRIP_CT   = 8'h0A;
    localparam logic [7:0] TRIP_CPU  = 8'h0B;
    localparam logic [7:0] TRIP_GND  = 8'h0E;
    localparam logic [7:0] TRIP_FAN  = 8'h14;
    localparam logic [7:0] TRIP_GA   = 8'h17;
    localparam logic [7:0] TRIP_MAIN = 8'h19;

    typedef struct packed {
        logic fan_drop;
        logic start_contact;
        logic overheat;
        logic low_current;
        logic ready;
        logic forward;
        logic reverse;
        logic major;
    } dso_flags_type;

    typedef struct packed {
        logic [15:0] fan_speed;
        logic [15:0] fan_full;
        logic [7:0]  temp;
        logic [15:0] current;
        logic [15:0] rated;
        logic        const_speed;
    } dso_meas_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } dso_trip_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } dso_bus_type;

    typedef struct packed {
        logic [2:0]                      pin_meta;
        logic [2:0]                      pin_sync;
        logic [1:0]                      fan_ctl;
        logic [1:0]                      lc_mode;
        logic                            run_src;
        logic                            sw_fwd;
        logic                            sw_rev;
        logic [7:0]                      oh_lvl;
        logic [15:0]                     lc_lvl;
        logic [NUM_TERM-1:0][SEL_W-1:0]  sel;
        logic [SEL_W-1:0]                relay_sel;
        logic                            tripped;
        logic                            major;
        logic [7:0]                      trip_code;
        logic                            dir_fwd;
        logic                            dir_rev;
        dso_flags_type                   flags;
        logic [NUM_TERM-1:0]             term_out;
        logic                            relay_out;
        logic                            alarm_out;
        logic [31:0]                     rdata;
    } dso_state_type;
endpackage : dso_pkg

// ==== core/dso_status_out.sv ====
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
// Functional notes
// - Fan drop when speed at most 75%.
// - Fan control 01 suppresses fan drop.
// - Fan drop readable in life-check monitor.
// - Start contact follows any run command.
// - Both run commands stop the motor.
// - Overheat when temperature exceeds level, 0..200.
// - Low current at or below level, max 2x.
// - Mode 00 any run, 01 constant speed.
// - Ready gates acceptance of run commands.
// - No main power means not ready.
// - Forward flag only while driving forward.
// - Reverse flag only while driving reverse.
// - Hardware trips raise major failure and alarm.
// - Fan, gate array, main circuit too.
// - Codes 40, 41, 42 route fan, start, overheat.
// - Code 43 routes low current.
// - Code 50 routes ready.
// - Code 52 routes reverse rotation.
// - Relay code 53 routes major failure.
module dso_status_out (
    input  logic                      sys_clk,
    input  logic                      sys_rst,
    input  dso_pkg::dso_bus_type      bus,
    output logic [31:0]               rdata,
    input  logic                      fwd_pin,
    input  logic                      rev_pin,
    input  logic                      main_power_pin,
    input  dso_pkg::dso_meas_type     meas,
    input  dso_pkg::dso_trip_type     trip,
    output logic [dso_pkg::NUM_TERM-1:0] term_out,
    output logic                      relay_out,
    output logic                      alarm_out,
    output logic                      motor_fwd,
    output logic                      motor_rev
);
    import dso_pkg::*;

    dso_state_type st_r;
    dso_state_type st_nxt;

    logic          cmd_fwd;
    logic          cmd_rev;
    logic          running;
    logic          lc_enable;
    logic          trip_clr;
    logic          hw_trip;
    logic [17:0]   fan_scaled;
    logic [17:0]   fan_limit;
    logic [15:0]   lc_max;

    // Maps a selector code onto the flag it names; unknown codes give 0.
    function automatic logic route(input logic [7:0] code,
                                   input dso_flags_type f);
        logic v;
        v = 1'b0;
        case (code)
            CODE_FAN: v = f.fan_drop;
            CODE_FR:  v = f.start_contact;
            CODE_OH:  v = f.overheat;
            CODE_LC:  v = f.low_current;
            CODE_RDY: v = f.ready;
            CODE_FWD: v = f.forward;
            CODE_REV: v = f.reverse;
            CODE_MAJ: v = f.major;
            default:  v = 1'b0;
        endcase
        return v;
    endfunction : route

    assign rdata     = st_r.rdata;
    assign term_out  = st_r.term_out;
    assign relay_out = st_r.relay_out;
    assign alarm_out = st_r.alarm_out;
    assign motor_fwd = st_r.dir_fwd;
    assign motor_rev = st_r.dir_rev;

    always_comb begin
        st_nxt = st_r;
        // Pins are asynchronous; only the second stage is ever read.
        st_nxt.pin_meta = {main_power_pin, rev_pin, fwd_pin};
        st_nxt.pin_sync = st_r.pin_meta;

        cmd_fwd = st_r.run_src ? st_r.sw_fwd : st_r.pin_sync[0];
        cmd_rev = st_r.run_src ? st_r.sw_rev : st_r.pin_sync[1];
        running = st_r.dir_fwd | st_r.dir_rev;

        hw_trip = (trip.code == TRIP_CT) || (trip.code == TRIP_CPU) ||
                  (trip.code == TRIP_GND) ||
                  (trip.code == TRIP_FAN) || (trip.code == TRIP_GA) ||
                  (trip.code == TRIP_MAIN);

        trip_clr = 1'b0;
        lc_max   = {meas.rated[14:0], 1'b0};

        if (bus.wr) begin
            if (bus.addr == OFS_CTRL) begin
                st_nxt.fan_ctl = bus.wdata[CTRL_FAN_LSB +: 2];
                st_nxt.lc_mode = bus.wdata[CTRL_LCM_LSB +: 2];
                st_nxt.run_src = bus.wdata[CTRL_SRC_BIT];
                st_nxt.sw_fwd  = bus.wdata[CTRL_SWF_BIT];
                st_nxt.sw_rev  = bus.wdata[CTRL_SWR_BIT];
                trip_clr       = bus.wdata[CTRL_CLR_BIT];
            end else if (bus.addr == OFS_OHLVL) begin
                if (bus.wdata[7:0] > OH_LVL_MAX) begin
                    st_nxt.oh_lvl = OH_LVL_MAX;
                end else begin
                    st_nxt.oh_lvl = bus.wdata[7:0];
                end
            end else if (bus.addr == OFS_LCLVL) begin
                if (bus.wdata[15:0] > lc_max) begin
                    st_nxt.lc_lvl = lc_max;
                end else begin
                    st_nxt.lc_lvl = bus.wdata[15:0];
                end
            end else if (bus.addr == OFS_RELAY) begin
                st_nxt.relay_sel = bus.wdata[SEL_W-1:0];
            end
            for (int i = 0; i < NUM_TERM; i++) begin
                if (bus.addr == 8'(OFS_SEL0 + OFS_STEP * 8'(i))) begin
                    st_nxt.sel[i] = bus.wdata[SEL_W-1:0];
                end
            end
        end

        // A clear and a new trip in one cycle keep the trip.
        if (trip_clr) begin
            st_nxt.tripped   = 1'b0;
            st_nxt.major     = 1'b0;
            st_nxt.trip_code = 8'h00;
        end
        if (trip.valid) begin
            st_nxt.tripped   = 1'b1;
            st_nxt.trip_code = trip.code;
            // Built on the cleared value, so a clear in the same cycle
            // cannot carry an old major failure into a soft trip.
            st_nxt.major     = st_nxt.major | hw_trip;
        end
        st_nxt.alarm_out = st_nxt.tripped;

        st_nxt.dir_fwd = st_r.flags.ready && cmd_fwd && !cmd_rev;
        st_nxt.dir_rev = st_r.flags.ready && cmd_rev && !cmd_fwd;

        // fan at or below 75 percent
        fan_scaled = 18'(meas.fan_speed) * 18'(FAN_DEN);
        fan_limit  = 18'(meas.fan_full) * 18'(FAN_NUM);
        st_nxt.flags.fan_drop = (fan_scaled <= fan_limit) &&
                                (st_r.fan_ctl != FAN_CTL_NO_WARN);
        st_nxt.flags.start_contact = cmd_fwd | cmd_rev;
        st_nxt.flags.overheat      = meas.temp > st_r.oh_lvl;

        if (st_r.lc_mode == LC_MODE_CONST) begin
            lc_enable = running & meas.const_speed;
        end else begin
            lc_enable = running;
        end
        st_nxt.flags.low_current = lc_enable &&
                                   (meas.current <= st_r.lc_lvl);
        st_nxt.flags.ready = st_r.pin_sync[2] & ~st_r.tripped;
        st_nxt.flags.forward = st_r.dir_fwd;
        st_nxt.flags.reverse = st_r.dir_rev;
        st_nxt.flags.major   = st_r.major;

        for (int i = 0; i < NUM_TERM; i++) begin
            st_nxt.term_out[i] = route(st_r.sel[i], st_r.flags);
        end
        st_nxt.relay_out = route(st_r.relay_sel, st_r.flags);

        // Read data stands for one cycle only, then returns to zero.
        st_nxt.rdata = 32'h0000_0000;
        if (bus.rd) begin
            if (bus.addr == OFS_CTRL) begin
                st_nxt.rdata[CTRL_FAN_LSB +: 2] = st_r.fan_ctl;
                st_nxt.rdata[CTRL_LCM_LSB +: 2] = st_r.lc_mode;
                st_nxt.rdata[CTRL_SRC_BIT]      = st_r.run_src;
                st_nxt.rdata[CTRL_SWF_BIT]      = st_r.sw_fwd;
                st_nxt.rdata[CTRL_SWR_BIT]      = st_r.sw_rev;
            end else if (bus.addr == OFS_OHLVL) begin
                st_nxt.rdata[7:0] = st_r.oh_lvl;
            end else if (bus.addr == OFS_LCLVL) begin
                st_nxt.rdata[15:0] = st_r.lc_lvl;
            end else if (bus.addr == OFS_RELAY) begin
                st_nxt.rdata[SEL_W-1:0] = st_r.relay_sel;
            end else if (bus.addr == OFS_LIFE) begin
                st_nxt.rdata[LIFE_FAN_BIT] = st_r.flags.fan_drop;
            end else if (bus.addr == OFS_STAT) begin
                st_nxt.rdata[7:0]                = st_r.flags;
                st_nxt.rdata[STAT_CODE_LSB +: 8] = st_r.trip_code;
                st_nxt.rdata[STAT_TRIP_BIT]      = st_r.tripped;
            end
            for (int i = 0; i < NUM_TERM; i++) begin
                if (bus.addr == 8'(OFS_SEL0 + OFS_STEP * 8'(i))) begin
                    st_nxt.rdata[SEL_W-1:0] = st_r.sel[i];
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r           <= '0;
            st_r.fan_ctl   <= RST_FAN_CTL;
            st_r.lc_mode   <= RST_LC_MODE;
            st_r.oh_lvl    <= RST_OH_LVL;
            st_r.lc_lvl    <= RST_LC_LVL;
            st_r.sel       <= {NUM_TERM{RST_SEL}};
            st_r.relay_sel <= RST_SEL;
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking dso_cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    chk_fan_suppress: assert property (
        st_r.fan_ctl == FAN_CTL_NO_WARN |=> !st_r.flags.fan_drop)
        else $error("Fan drop raised while suppressed.");

    chk_fan_drop: assert property (
        (st_r.fan_ctl != FAN_CTL_NO_WARN) &&
        (meas.fan_speed * 4 <= meas.fan_full * 3)
        |=> st_r.flags.fan_drop)
        else $error("Fan drop missed at low speed.");

    chk_both_stop: assert property (
        cmd_fwd && cmd_rev |=> !st_r.dir_fwd && !st_r.dir_rev)
        else $error("Motor driven with both commands.");

    chk_no_power: assert property (
        !st_r.pin_sync[2] |=> !st_r.flags.ready)
        else $error("Ready without main power.");

    chk_ready_gate: assert property (
        !st_r.flags.ready |=> !st_r.dir_fwd ##1 !st_r.flags.forward)
        else $error("Command acted on while not ready.");

    chk_overheat: assert property (
        meas.temp > st_r.oh_lvl |=> st_r.flags.overheat)
        else $error("Overheat flag missing.");

    chk_rotation_flags: assert property (
        st_r.dir_fwd |=> st_r.flags.forward && !st_r.flags.reverse)
        else $error("Forward flag wrong while driving.");

    chk_major_trip: assert property (
        trip.valid && trip.code == TRIP_GND
        |=> st_r.alarm_out ##1 st_r.flags.major)
        else $error("Major failure not raised on trip.");

    chk_term_route: assert property (
        st_r.sel[0] == CODE_FR
        |=> st_r.term_out[0] == $past(st_r.flags.start_contact))
        else $error("Terminal does not follow start contact.");

    chk_relay_major: assert property (
        st_r.relay_sel == CODE_MAJ
        |=> st_r.relay_out == $past(st_r.flags.major))
        else $error("Relay does not follow major failure.");

    chk_read_pulse: assert property (
        !bus.rd |=> st_r.rdata == 32'h0000_0000)
        else $error("Read data outside its cycle.");
endmodule : dso_status_out

// ==== tb/dso_status_out_tb.sv ====
`timescale 1ns/100ps
module dso_status_out_tb;
    import dso_pkg::*;
    logic                sys_clk = 1'b0;
    logic                sys_rst = 1'b1;
    dso_bus_type         bus;
    logic [31:0]         rdata;
    logic                fwd_pin, rev_pin, main_power_pin;
    dso_meas_type        meas;
    dso_trip_type        trip;
    logic [NUM_TERM-1:0] term_out;
    logic                relay_out, alarm_out, motor_fwd, motor_rev;
    logic [NUM_TERM:0]   seen;
    logic [31:0]         v;
    logic [7:0]          hw_codes [6];
    int                  miscompares = 0;
    int                  comparisons = 0;

    always #4 sys_clk = ~sys_clk;

    dso_status_out uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus),
        .rdata(rdata), .fwd_pin(fwd_pin), .rev_pin(rev_pin),
        .main_power_pin(main_power_pin), .meas(meas), .trip(trip),
        .term_out(term_out), .relay_out(relay_out), .alarm_out(alarm_out),
        .motor_fwd(motor_fwd), .motor_rev(motor_rev));
    dso_term_load load (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .term_in(term_out), .relay_in(relay_out), .seen(seen));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : bus_rd

    // Pins need two sync stages, then flag and terminal stages.
    task automatic settle();
        repeat (8) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic flags_are(input logic [7:0] exp);
        bus_rd(OFS_STAT, v);
        check({24'h000000, v[7:0]}, {24'h000000, exp});
    endtask : flags_are

    task automatic tally_and_finish();
        $display("Compares %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #(8 * 20000);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        hw_codes = '{TRIP_CT, TRIP_CPU, TRIP_GND, TRIP_FAN, TRIP_GA, TRIP_MAIN};
        bus = '0;
        trip = '0;
        fwd_pin = 1'b0;
        rev_pin = 1'b0;
        main_power_pin = 1'b1;
        meas.fan_full = 16'h03E8;
        meas.fan_speed = 16'h02EE;
        meas.temp = 8'h79;
        meas.rated = 16'h0064;
        meas.current = 16'h0032;
        meas.const_speed = 1'b0;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        bus_rd(OFS_CTRL, v);
        check(v, 32'h00000000);
        bus_rd(OFS_OHLVL, v);
        check(v, {24'h000000, RST_OH_LVL});
        bus_rd(OFS_SEL0, v);
        check(v, 32'h00000000);
        bus_wr(8'h30, 32'hFFFFFFFF);
        bus_rd(8'h30, v);
        check(v, 32'h00000000);
        bus_wr(OFS_OHLVL, 32'h000000FF);
        bus_rd(OFS_OHLVL, v);
        check(v, {24'h000000, OH_LVL_MAX}); // Level stops at its top.
        bus_wr(OFS_LCLVL, 32'h0000FFFF);
        bus_rd(OFS_LCLVL, v);
        check(v, 32'h000000C8); // Level stops at twice rated.
        bus_wr(OFS_OHLVL, 32'h00000078);
        bus_wr(OFS_LCLVL, 32'h00000032);
        bus_wr(OFS_SEL0, {24'h000000, CODE_FAN});
        bus_wr(OFS_SEL0 + OFS_STEP, {24'h000000, CODE_FR});
        bus_wr(OFS_SEL0 + 8'h08, {24'h000000, CODE_OH});
        bus_wr(OFS_SEL0 + 8'h0C, {24'h000000, CODE_LC});
        bus_wr(OFS_SEL0 + 8'h10, {24'h000000, CODE_RDY});
        bus_wr(OFS_RELAY, {24'h000000, CODE_MAJ});
        fwd_pin <= 1'b1;
        settle();
        check(seen, 6'h1F); // Each routed flag shows on its pin.
        flags_are(8'hFC); // Fan drop at exactly three quarters.
        bus_rd(OFS_LIFE, v);
        check(v[LIFE_FAN_BIT], 1'b1); // Fan drop in life check.
        check({motor_fwd, motor_rev}, 2'b10); // Forward drive.
        meas.fan_speed <= 16'h02EF;
        meas.temp <= 8'h78;
        meas.current <= 16'h0033;
        settle();
        check(seen, 6'h12); // Low current gone above level.
        flags_are(8'h4C); // Equal temperature is no warning.
        meas.fan_speed <= 16'h02EE;
        meas.temp <= 8'h79;
        meas.current <= 16'h0032;
        bus_wr(OFS_CTRL, 32'h00000005);
        settle();
        flags_are(8'h6C); // Low current waits for constant speed.
        meas.const_speed <= 1'b1;
        settle();
        flags_are(8'h7C); // Fan setting one hides fan drop.
        bus_wr(OFS_CTRL, 32'h00000000);
        bus_wr(OFS_SEL0, {24'h000000, CODE_REV});
        bus_wr(OFS_SEL0 + OFS_STEP, {24'h000000, CODE_FWD});
        fwd_pin <= 1'b0;
        rev_pin <= 1'b1;
        settle();
        check(seen[1:0], 2'b01); // Reverse routed on its code.
        check({motor_fwd, motor_rev}, 2'b01); // Reverse drive.
        fwd_pin <= 1'b1;
        settle();
        check({motor_fwd, motor_rev}, 2'b00); // Both commands stop.
        flags_are(8'hE8); // Start contact stays with both commands.
        rev_pin <= 1'b0;
        main_power_pin <= 1'b0;
        settle();
        check(seen[4], 1'b0); // No main power means not ready.
        check({motor_fwd, motor_rev}, 2'b00); // No drive when not ready.
        main_power_pin <= 1'b1;
        fwd_pin <= 1'b0;
        bus_wr(OFS_CTRL, 32'h00000110);
        settle();
        flags_are(8'hFC); // Start contact from register source.
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk);
            trip.valid <= 1'b1;
            trip.code <= hw_codes[i];
            @(posedge sys_clk);
            trip.valid <= 1'b0;
            settle();
            check({alarm_out, seen[NUM_TERM]}, 2'b11); // Alarm, relay.
            check({motor_fwd, seen[4]}, 2'b00); // Trip stops drive.
            bus_rd(OFS_STAT, v);
            check(v[16:0], {1'b1, hw_codes[i], 8'hE1}); // Major latched.
            bus_wr(OFS_CTRL, 32'h00010110);
            settle();
            check({alarm_out, seen[NUM_TERM]}, 2'b00); // Cleared.
        end
        @(posedge sys_clk);
        trip.valid <= 1'b1;
        trip.code <= 8'h05;
        @(posedge sys_clk);
        trip.valid <= 1'b0;
        settle();
        check({alarm_out, seen[NUM_TERM]}, 2'b10); // Soft trip no major.
        tally_and_finish();
    end
endmodule : dso_status_out_tb

// ==== tb/dso_term_load.sv ====
`timescale 1ns/100ps
// External equipment on the terminals: it latches what it sees each cycle,
// so the bench judges the terminals as the far side receives them.
module dso_term_load (
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    input  wire logic [dso_pkg::NUM_TERM-1:0] term_in,
    input  wire logic                        relay_in,
    output logic      [dso_pkg::NUM_TERM:0]   seen
);
    import dso_pkg::*;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            seen <= '0;
        end else begin
            seen <= {relay_in, term_in};
        end
    end
endmodule : dso_term_load
